// ===== rtl/adcc_top.sv
// Conversion control, master clock selection and serial output port.
`default_nettype none

module adcc_top (
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              RST_N_I,
  input  wire logic              CONVERT_N_I,
  input  wire logic              CS_N_I,
  input  wire logic              MCLK_I,
  input  wire logic              PORT_ROLE_SELECT_I,
  input  wire logic              CODING_SELECT_I,
  input  wire logic              DITHER_SELECT_I,
  input  wire adcc_pkg::adcc_word_t SAMPLE_I,
  input  wire logic              SCLK_I,
  output var  logic              SCLK_O,
  output var  logic              SCLK_OE_O,
  output var  logic              SERIAL_OUT_O,
  output var  logic              SERIAL_OUT_OE_O,
  output var  logic              READY_N_O,
  output var  logic              ANALOG_START_O,
  output var  logic              MCLK_EXT_O,
  output var  logic              MCLK_STOPPED_O
);
  import adcc_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] sy1;
  logic [SYNC_W-1:0] sy2;
  logic [SYNC_W-1:0] sy3;

  // Every pin passes two flops; the third stage only serves edge finding.
  // The reset image holds the device reset pin asserted, so no false release
  // pulse or stray boot count follows the system reset.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sy1 <= 8'h0C;
      sy2 <= 8'h0C;
      sy3 <= 8'h0C;
    end else begin
      sy1 <= {DITHER_SELECT_I, CODING_SELECT_I, PORT_ROLE_SELECT_I, SCLK_I,
              MCLK_I, CS_N_I, CONVERT_N_I, RST_N_I};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  logic dev_rst;
  logic convert_n_low;
  logic cs_n;
  logic role_ssc;
  logic sclk_rise;
  logic mclk_lvl;
  logic mclk_edge;

  assign dev_rst   = ~sy2[SY_RST];                         // [R8]
  assign convert_n_low  = ~sy2[SY_CONVERT_N];
  assign cs_n      = sy2[SY_CS];
  assign role_ssc  = sy2[SY_ROLE];                         // [R2] [R3]
  assign sclk_rise = sy2[SY_SCLK] & ~sy3[SY_SCLK];
  assign mclk_lvl  = sy2[SY_MCLK];
  assign mclk_edge = sy2[SY_MCLK] & ~sy3[SY_MCLK];

  // ****************************************************************
  // Master clock selection
  // ****************************************************************
  logic [7:0] idle_cnt;
  logic [3:0] osc_cnt;
  logic       ext_mode;
  logic       osc_tick;
  logic       mtick;

  assign ext_mode = (idle_cnt < 8'(MCLK_LOSS_CYC));
  assign osc_tick = (osc_cnt == 4'(OSC_DIV - 1));
  // A toggling pin wins; a static low runs the oscillator; a static high stops all.
  assign mtick = ext_mode ? mclk_edge : (~mclk_lvl & osc_tick);   // [R13] [R14] [R15]

  // Cycles since the last master clock edge decide whether a clock is present.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      idle_cnt <= 8'hFF;
    end else if (mclk_edge) begin
      idle_cnt <= 8'h00;
    end else if (ext_mode) begin
      idle_cnt <= idle_cnt + 8'h01;                        // [R15]
    end
  end

  // The on-chip oscillator is a divider that halts while the pin is high.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      osc_cnt <= 4'h0;
    end else if (mclk_lvl || ext_mode || osc_tick) begin
      osc_cnt <= 4'h0;                                     // [R14]
    end else begin
      osc_cnt <= osc_cnt + 4'h1;                           // [R13]
    end
  end

  // Clock source status for the surrounding logic.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MCLK_EXT_O     <= 1'b0;
      MCLK_STOPPED_O <= 1'b0;
    end else begin
      MCLK_EXT_O     <= ext_mode;
      MCLK_STOPPED_O <= ~ext_mode & mclk_lvl;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  adcc_convert_n_state_t state;
  adcc_cnt_t        tick_cnt;
  adcc_word_t       result;
  logic [15:0]      lfsr;
  logic             rst_prev;
  logic             boot_done;
  logic             early;
  adcc_word_t       dith;
  adcc_word_t       shaped;

  adcc_stream_if #(.WIDTH(WORD_BITS)) convert_n_s ();
  adcc_stream_if #(.WIDTH(WORD_BITS)) port_s ();

  assign boot_done = (state == CV_BOOT) && mtick && (tick_cnt == CNT_W'(RESET_TICKS - 1));
  assign early     = (state == CV_RUN) && mtick
                   && (tick_cnt == CNT_W'(CONVERT_N_TICKS - 1 - EARLY_TICKS));

  // Dither nudges the LSB by a pseudo-random bit; saturation avoids wrap.
  assign dith = (sy2[SY_DITH] && lfsr[0] && (SAMPLE_I != 16'hFFFF))
              ? SAMPLE_I + 16'h0001 : SAMPLE_I;            // [R6]

  // Sample arrives as offset binary over the bipolar span.
  always_comb begin
    if (sy2[SY_CODE]) begin
      shaped = {~dith[15], dith[14:0]};                    // [R4]
    end else if (dith[15]) begin
      shaped = {dith[14:0], 1'b0};                         // [R5]
    end else begin
      shaped = 16'h0000;                                   // [R5]
    end
  end

  // Dither source steps once per master clock, so it stops with the clock.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      lfsr <= LFSR_SEED;
    end else if (mtick) begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
    end
  end

  // A pulse on reset release starts the analog circuitry.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rst_prev       <= 1'b1;
      ANALOG_START_O <= 1'b0;
    end else begin
      rst_prev       <= dev_rst;
      ANALOG_START_O <= rst_prev & ~dev_rst;               // [R8]
    end
  end

  // Boot count, then convert on a low convert input; the idle test is a level,
  // so a convert input still low when ready falls starts the next cycle at once.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state    <= CV_BOOT;
      tick_cnt <= '0;
      result   <= '0;
    end else if (dev_rst) begin
      state    <= CV_BOOT;                                 // [R8]
      tick_cnt <= '0;
    end else begin
      case (state)
        CV_BOOT: begin
          if (boot_done) begin
            state    <= CV_IDLE;
            tick_cnt <= '0;
          end else if (mtick) begin
            tick_cnt <= tick_cnt + 1'b1;
          end
        end
        CV_IDLE: begin
          if (convert_n_low) begin
            state    <= CV_RUN;                            // [R10] [R12]
            tick_cnt <= '0;
          end
        end
        CV_RUN: begin
          if (mtick && (tick_cnt == CNT_W'(CONVERT_N_TICKS - 1))) begin
            state  <= CV_PUSH;
            result <= shaped;
          end else if (mtick) begin
            tick_cnt <= tick_cnt + 1'b1;
          end
        end
        CV_PUSH: begin
          // A full queue holds the sequencer here, so no word is dropped.
          if (convert_n_s.ready) begin
            state <= CV_IDLE;
          end
        end
        default: begin
          state <= CV_BOOT;
        end
      endcase
    end
  end

  assign convert_n_s.valid = (state == CV_PUSH);
  assign convert_n_s.data  = result;

  adcc_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .flush_i (dev_rst),
    .wr      (convert_n_s),
    .rd      (port_s)
  );

  // ****************************************************************
  // Serial output port
  // ****************************************************************
  adcc_word_t       shreg;
  logic [BIT_W-1:0] bits_left;
  logic             reading;
  logic             ssc_run;
  logic             load;
  logic             bit_edge;
  logic             last_bit;

  // The output register takes a new word whenever no read is in progress.
  assign port_s.ready = ~reading & ~dev_rst;
  assign load         = port_s.valid & port_s.ready;      // [R11]
  assign bit_edge     = (bits_left != '0) && (ssc_run ? (mtick & ~SCLK_O)
                      : (~role_ssc & ~cs_n & sclk_rise)); // [R17]
  assign last_bit     = bit_edge && (bits_left == BIT_W'(1));

  // Shift register: MSB on the pin at load, one bit further per rising edge.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      shreg        <= '0;
      bits_left    <= '0;
      reading      <= 1'b0;
      SERIAL_OUT_O <= 1'b0;
    end else if (dev_rst) begin
      shreg        <= '0;
      bits_left    <= '0;
      reading      <= 1'b0;
      SERIAL_OUT_O <= 1'b0;
    end else if (load) begin
      shreg        <= port_s.data;
      bits_left    <= BIT_W'(WORD_BITS);                   // [R20]
      SERIAL_OUT_O <= port_s.data[WORD_BITS-1];            // [R16]
    end else if (bit_edge) begin
      shreg        <= {shreg[WORD_BITS-2:0], 1'b0};
      SERIAL_OUT_O <= shreg[WORD_BITS-2];                  // [R17]
      bits_left    <= bits_left - 1'b1;
      reading      <= ~last_bit;
    end
  end

  // Ready: low after boot or a load, high after the last bit or just before
  // a fresh word would overwrite one that nobody started to read.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      READY_N_O <= 1'b1;
    end else if (dev_rst) begin
      READY_N_O <= 1'b1;
    end else if (load || boot_done) begin
      READY_N_O <= 1'b0;                                   // [R9] [R11]
    end else if (last_bit || (early && !reading)) begin
      READY_N_O <= 1'b1;                                   // [R18]
    end
  end

  // Self-clocked run starts only if chip select is low as ready falls.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ssc_run <= 1'b0;
    end else if (dev_rst || cs_n || !role_ssc || last_bit) begin
      ssc_run <= 1'b0;
    end else if (load) begin
      ssc_run <= 1'b1;                                     // [R16]
    end
  end

  // Serial clock out is the master clock halved; it idles low between words.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SCLK_O <= 1'b0;
    end else if (!ssc_run) begin
      SCLK_O <= 1'b0;
    end else if (mtick) begin
      SCLK_O <= ~SCLK_O;                                   // [R2]
    end
  end

  // Pin drivers let go whenever chip select is high.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SERIAL_OUT_OE_O <= 1'b0;
      SCLK_OE_O       <= 1'b0;
    end else begin
      SERIAL_OUT_OE_O <= ~cs_n;                            // [R1]
      SCLK_OE_O       <= role_ssc & ~cs_n;                 // [R19] [R3]
    end
  end

endmodule : adcc_top

`default_nettype wire

// ===== rtl/adcc_pkg.sv
// Constants, types and timing counts shared by the converter control block.
// What this block does
// R1 - Chip select high keeps the serial data output in high impedance.
// R2 - Role select high: self-clocked master, device drives serial clock and data.
// R3 - Role select low: external logic supplies the serial clock that shifts data.
// R4 - Coding select high: words come out in two's complement, bipolar span.
// R5 - Coding select low: words come out in straight binary, zero to positive span.
// R6 - Dither select high adds dither to words; low gives plain quantized words.
// R7 - The controlling party must reset the device after power-up.
// R8 - Reset pin low holds logic in reset; release starts the analog circuitry.
// R9 - Ready flag falls once the reset sequence has completed.
// R10 - Convert input taken low begins a conversion cycle.
// R11 - A finished conversion loads the output register, then ready falls.
// R12 - Convert still low when ready falls starts the next conversion at once.
// R13 - Master clock pin tied low enables the on-chip oscillator.
// R14 - Master clock pin held high stops every internal clock and the oscillator.
// R15 - A logic-level clock toggling on the master clock pin is the master clock.
// R16 - Self-clocked with select low when ready falls: word shifts out MSB first.
// R17 - Data advances on rising serial clock edges; reader captures on the next.
// R18 - Ready rises after the last bit, or two master cycles before new data.
// R19 - Self-clocked: serial clock output is tri-stated while chip select is high.
// R20 - Conversion words are 16 bits, so a full read takes sixteen clocks.
`default_nettype none

package adcc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 25;
  localparam int OSC_PERIOD_NS  = 200;
  localparam int OSC_DIV        = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MCLK_LOSS_NS   = 2000;
  localparam int MCLK_LOSS_CYC  = (MCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONVERT_N_TICKS     = 40;
  localparam int RESET_TICKS    = 16;
  localparam int EARLY_TICKS    = 2;

  // ****************************************************************
  // Data path shape
  // ****************************************************************
  localparam int WORD_BITS      = 16;
  localparam int FIFO_DEPTH     = 16;
  localparam int CNT_W          = 8;
  localparam int BIT_W          = 5;
  localparam int SYNC_W         = 8;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // Positions of the pins inside the synchroniser vector.
  localparam int SY_RST   = 0;
  localparam int SY_CONVERT_N  = 1;
  localparam int SY_CS    = 2;
  localparam int SY_MCLK  = 3;
  localparam int SY_SCLK  = 4;
  localparam int SY_ROLE  = 5;
  localparam int SY_CODE  = 6;
  localparam int SY_DITH  = 7;

  typedef logic [WORD_BITS-1:0] adcc_word_t;
  typedef logic [CNT_W-1:0]     adcc_cnt_t;

  typedef enum logic [1:0] {
    CV_BOOT,
    CV_IDLE,
    CV_RUN,
    CV_PUSH
  } adcc_convert_n_state_t;

endpackage : adcc_pkg

`default_nettype wire

// ===== rtl/adcc_stream_if.sv
// Valid/ready word stream between the converter, the FIFO and the serial port.
`default_nettype none

interface adcc_stream_if #(
  parameter int WIDTH = 16
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : adcc_stream_if

`default_nettype wire

// ===== rtl/adcc_fifo.sv
// Synchronous word FIFO with valid/ready on both sides.
`default_nettype none

module adcc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic flush_i,
  adcc_stream_if.snk wr,
  adcc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty without a separate counter.
  assign empty    = (wptr == rptr);
  assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data  = mem[rptr[AW-1:0]];

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_i) begin
    if (wr.valid && !full) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end

  // Pointers move on accepted handshakes; a flush empties the queue.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
    end else if (flush_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (wr.valid && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (rd.ready && !empty) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule : adcc_fifo

`default_nettype wire

// ===== tb/adcc_assertions.sv
// Pin-level checker for the converter control block.
`default_nettype none

module adcc_assertions (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic RST_N_I,
  input wire logic CS_N_I,
  input wire logic PORT_ROLE_SELECT_I,
  input wire logic SCLK_OE_O,
  input wire logic SERIAL_OUT_OE_O,
  input wire logic READY_N_O,
  input wire logic ANALOG_START_O,
  input wire logic MCLK_STOPPED_O
);
  // Pins pass a two-stage synchroniser, so levels are given five cycles to settle.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_data_float: assert property (CS_N_I [*5] |-> !SERIAL_OUT_OE_O)
    else $error("data pin driven while deselected");
  a_clk_float: assert property (CS_N_I [*5] |-> !SCLK_OE_O)
    else $error("clock pin driven while deselected");
  a_master_drive: assert property ((PORT_ROLE_SELECT_I && !CS_N_I) [*5] |-> SCLK_OE_O)
    else $error("master role does not drive the clock");
  a_slave_clk_in: assert property ((!PORT_ROLE_SELECT_I) [*5] |-> !SCLK_OE_O)
    else $error("slave role drives the clock");
  a_reset_holds: assert property ((!RST_N_I) [*5] |-> READY_N_O)
    else $error("ready low during device reset");
  a_analog_start: assert property ($rose(RST_N_I) |-> ##[1:6] ANALOG_START_O)
    else $error("no analog start after reset release");
  a_start_pulse: assert property (ANALOG_START_O |=> !ANALOG_START_O)
    else $error("analog start longer than one cycle");
  a_reset_ready: assert property ($rose(RST_N_I) |-> ##[1:400] !READY_N_O)
    else $error("ready did not fall after reset");
  a_stop_freeze: assert property ((MCLK_STOPPED_O && READY_N_O) [*4] |=> READY_N_O)
    else $error("conversion ended with clocks stopped");
endmodule : adcc_assertions

bind adcc_top adcc_assertions i_adcc_assertions (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I),
  .PORT_ROLE_SELECT_I(PORT_ROLE_SELECT_I), .SCLK_OE_O(SCLK_OE_O),
  .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .READY_N_O(READY_N_O),
  .ANALOG_START_O(ANALOG_START_O), .MCLK_STOPPED_O(MCLK_STOPPED_O));

`default_nettype wire

// ===== tb/adcc_reader.sv
// Model of the host logic that reads conversion words from the serial port.
`default_nettype none

module adcc_reader (
  input  wire logic sclk_pin_i,
  input  wire logic sdo_pin_i,
  output var  logic sclk_drv_o
);
  import adcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Data seen just before a clock edge; the device moves data on the same edge.
  wire #1 sdo_late = sdo_pin_i;

  // The host clock stands low outside frames so no stray edge advances data.
  initial sclk_drv_o = 1'b0;

  // Slave read at 200 ns per bit: capture the present bit, then raise the clock.
  task automatic read_slave(output adcc_word_t w);
    w = '0;
    #7;
    for (int i = 0; i < WORD_BITS; i++) begin
      #100;
      w = {w[WORD_BITS-2:0], sdo_pin_i};
      sclk_drv_o = 1'b1;
      #100;
      sclk_drv_o = 1'b0;
    end
  endtask : read_slave

  // Master read: the device clocks, each rising edge captures the bit it finds.
  task automatic read_master(output adcc_word_t w);
    w = '0;
    repeat (WORD_BITS) begin
      @(posedge sclk_pin_i);
      w = {w[WORD_BITS-2:0], sdo_late};
    end
  endtask : read_master
endmodule : adcc_reader

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the converter control block.
`default_nettype none

module tb_top;
  import adcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam adcc_word_t TS [4] = '{16'h1234, 16'h1234, 16'hC001, 16'h8000};
  localparam adcc_word_t TE [4] = '{16'h9234, 16'h0000, 16'h8002, 16'h0000};
  localparam adcc_word_t TM [4] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFE};
  localparam logic [3:0] TC = 4'b1001;
  localparam logic [3:0] TD = 4'b1000;

  logic       clk, sys_rst, rst_n, convert_n_n, cs_n, role, coding, dither;
  logic       mclk_lvl, mclk_run, sclk_drv;
  logic       sclk_o, sclk_oe, serial_out, sdo_oe, ready_n, an_start, mclk_ext, mclk_stop;
  logic [3:0] mclk_div;
  adcc_word_t sample;
  int         err_count;
  int         check_count;
  int         convert_n_total;
  wire        mclk_pin = mclk_run ? mclk_div[3] : mclk_lvl;
  wire        sclk_pin = sclk_oe ? sclk_o : sclk_drv;
  wire        sdo_pin = sdo_oe ? serial_out : 1'bz;

  adcc_top i_adcc_top (.CLK_I(clk), .SYS_RST_I(sys_rst), .RST_N_I(rst_n),
    .CONVERT_N_I(convert_n_n), .CS_N_I(cs_n), .MCLK_I(mclk_pin), .PORT_ROLE_SELECT_I(role),
    .CODING_SELECT_I(coding), .DITHER_SELECT_I(dither), .SAMPLE_I(sample),
    .SCLK_I(sclk_pin), .SCLK_O(sclk_o), .SCLK_OE_O(sclk_oe), .SERIAL_OUT_O(serial_out),
    .SERIAL_OUT_OE_O(sdo_oe), .READY_N_O(ready_n), .ANALOG_START_O(an_start),
    .MCLK_EXT_O(mclk_ext), .MCLK_STOPPED_O(mclk_stop));
  adcc_reader i_adcc_reader (.sclk_pin_i(sclk_pin), .sdo_pin_i(sdo_pin),
    .sclk_drv_o(sclk_drv));

  // Clock at 40 MHz; the external master clock divides it to a 400 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) if (mclk_run) mclk_div <= mclk_div + 4'h1;

  task automatic chk(input string what, input adcc_word_t exp, input adcc_word_t got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic span(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : span

  // Bounded wait for a ready level; a hang shows up as a count of 1000.
  task automatic wait_rdy(input logic v, output int n);
    for (n = 0; n < 1000 && ready_n !== v; n++) @(negedge clk);
  endtask : wait_rdy

  // Pulses convert, then returns how long ready stood high before it fell.
  task automatic convert_n(input adcc_word_t s, output int hi);
    int n;
    sample = s;
    convert_n_n = 1'b0;
    repeat (4) @(negedge clk);
    convert_n_n = 1'b1;
    wait_rdy(1'b1, n);
    wait_rdy(1'b0, hi);
    // Ready may still stand low from an unread word, so time from the request.
    convert_n_total = 4 + n + hi;
  endtask : convert_n

  task automatic rd_chk(input string what, input adcc_word_t exp, input adcc_word_t mask);
    adcc_word_t w;
    i_adcc_reader.read_slave(w);
    @(negedge clk);
    chk(what, exp, w & mask);
  endtask : rd_chk

  task automatic t_reset;
    int n;
    repeat (6) @(negedge clk);
    chk("ready in reset", 16'h1, {15'h0, ready_n});
    rst_n = 1'b1;
    wait_rdy(1'b0, n);
    span("reset to ready", 120, 300, n);
    rd_chk("reset word", 16'h0, 16'hFFFF);
  endtask : t_reset

  task automatic t_coding;
    int hi;
    for (int i = 0; i < 4; i++) begin
      coding = TC[i];
      dither = TD[i];
      convert_n(TS[i], hi);
      span("conversion time", 300, 345, convert_n_total);
      rd_chk("coded word", TE[i], TM[i]);
      repeat (4) @(negedge clk);
      chk("ready after read", 16'h1, {15'h0, ready_n});
    end
  endtask : t_coding

  task automatic t_hold;
    int n;
    dither = 1'b0;
    sample = 16'h0F0F;
    convert_n_n = 1'b0;
    wait_rdy(1'b0, n);
    sample = 16'h7777;
    repeat (8) @(negedge clk);
    convert_n_n = 1'b1;
    wait_rdy(1'b1, n);
    span("restart", 250, 345, n);
    wait_rdy(1'b0, n);
    rd_chk("restart word", 16'hF777, 16'hFFFF);
  endtask : t_hold

  task automatic t_master;
    adcc_word_t w;
    int hi;
    role = 1'b1;
    fork
      i_adcc_reader.read_master(w);
      convert_n(16'hA5C3, hi);
    join
    @(negedge clk);
    chk("master word", 16'h25C3, w);
    repeat (4) @(negedge clk);
    chk("ready after master", 16'h1, {15'h0, ready_n});
  endtask : t_master

  task automatic t_deselect;
    int hi;
    cs_n = 1'b1;
    convert_n(16'h1111, hi);
    repeat (40) @(negedge clk);
    chk("data enable", 16'h0, {15'h0, sdo_oe});
    chk("clock enable", 16'h0, {15'h0, sclk_oe});
    chk("ready unread", 16'h0, {15'h0, ready_n});
    role = 1'b0;
    cs_n = 1'b0;
    convert_n(16'h2222, hi);
    span("early rise", 14, 24, hi);
    rd_chk("overwritten word", 16'hA222, 16'hFFFF);
  endtask : t_deselect

  task automatic t_clocks;
    int n;
    mclk_lvl = 1'b1;
    sample = 16'h0001;
    repeat (120) @(negedge clk);
    chk("clocks stopped", 16'h1, {15'h0, mclk_stop});
    convert_n_n = 1'b0;
    repeat (4) @(negedge clk);
    convert_n_n = 1'b1;
    repeat (200) @(negedge clk);
    chk("no conversion", 16'h1, {15'h0, ready_n});
    mclk_lvl = 1'b0;
    wait_rdy(1'b0, n);
    chk("oscillator on", 16'h0, {14'h0, mclk_stop, mclk_ext});
    rd_chk("oscillator word", 16'h8001, 16'hFFFF);
    mclk_run = 1'b1;
    convert_n(16'h4000, n);
    span("external conversion", 600, 680, n);
    chk("external clock", 16'h1, {15'h0, mclk_ext});
    rd_chk("external word", 16'hC000, 16'hFFFF);
    mclk_run = 1'b0;
  endtask : t_clocks

  task automatic final_report;
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // Main sequence; the device reset pin stays low through the system reset.
  initial begin
    err_count = 0;
    check_count = 0;
    sys_rst = 1'b1;
    rst_n = 1'b0;
    convert_n_n = 1'b1;
    cs_n = 1'b0;
    role = 1'b0;
    coding = 1'b1;
    dither = 1'b0;
    mclk_lvl = 1'b0;
    mclk_run = 1'b0;
    mclk_div = 4'h0;
    sample = '0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_coding;
    t_hold;
    t_master;
    t_deselect;
    t_clocks;
    final_report;
  end

  // Watchdog: the tests need about 6000 cycles, so 20000 means a hang.
  initial begin
    repeat (20000) @(negedge clk);
    err_count++;
    final_report;
  end
endmodule : tb_top

`default_nettype wire
